// *** bmx_pkg.sv ***
// Constants and carrier types of the two-channel bus mux control block.
// Assumes a 100 MHz core clock and a 2-wire upstream link clocked by its clock line.
package bmx_pkg;

	// ==========================================================
	// Register pointers.
	localparam logic [7:0] REG_FAULT = 8'h00; // Fault status, a write clears the refused-connection flag.
	localparam logic [7:0] REG_CFG   = 8'h02; // Connection configuration.
	localparam logic [7:0] REG_SW    = 8'h03; // Channel switch control.

	// ==========================================================
	// Field positions.
	localparam int CFG_CONN_ANY_BIT = 5; // Connect regardless of logic state.
	localparam int CFG_MASS_BIT     = 2; // Mass write address enable.
	localparam int CFG_TMO_HI_BIT   = 1; // Timeout select, high bit.
	localparam int CFG_TMO_LO_BIT   = 0; // Timeout select, low bit.
	localparam int SW_CH1_BIT       = 7; // Channel 1 switch state.
	localparam int SW_CH2_BIT       = 6; // Channel 2 switch state.
	localparam int LS_CH1_BIT       = 3; // Channel 1 logic state.
	localparam int LS_CH2_BIT       = 2; // Channel 2 logic state.
	localparam int FLT_CONN_BIT     = 7; // Upstream connected.
	localparam int FLT_F1_BIT       = 6; // Channel 1 fault input level.
	localparam int FLT_F2_BIT       = 5; // Channel 2 fault input level.
	localparam int FLT_NOFAIL_BIT   = 2; // Low after a refused connection.
	localparam int FLT_TMO_BIT      = 0; // Stuck-low timeout in progress.

	// ==========================================================
	// Addresses and select codes.
	localparam logic [6:0] MASS_ADDR    = 7'h5e; // Broadcast write address.
	localparam logic [1:0] TMO_SEL_OFF  = 2'h0;  // Timeout disabled.
	localparam logic [1:0] TMO_SEL_30   = 2'h1;
	localparam logic [1:0] TMO_SEL_15   = 2'h2;
	localparam logic [1:0] TMO_SEL_7P5  = 2'h3;

	// ==========================================================
	// Timing.
	localparam int CORE_PERIOD_PS = 10_000;        // 100 MHz.
	localparam int TMO_30_US      = 30_000;        // 30 ms.
	localparam int TMO_15_US      = 15_000;        // 15 ms.
	localparam int TMO_7P5_US     = 7_500;         // 7.5 ms.
	localparam int TMO_30_CYC     = TMO_30_US * 1000 / CORE_PERIOD_PS * 1000;
	localparam int TMO_15_CYC     = TMO_15_US * 1000 / CORE_PERIOD_PS * 1000;
	localparam int TMO_7P5_CYC    = TMO_7P5_US * 1000 / CORE_PERIOD_PS * 1000;
	localparam int TMR_W          = 22;            // Holds the 30 ms count.

	// ==========================================================
	// Carrier types.
	typedef struct packed {
		logic       conn_any;   // Connection policy override.
		logic       mass_wr_en; // Broadcast address accepted.
		logic [1:0] tmo_sel;    // Timeout select.
	} bmx_cfg_t;

	localparam bmx_cfg_t CFG_RESET = '{conn_any: 1'b0, mass_wr_en: 1'b1, tmo_sel: TMO_SEL_OFF};

	typedef struct packed {
		logic connected; // Buffer path active.
		logic fault1;    // Channel 1 fault input level.
		logic fault2;    // Channel 2 fault input level.
		logic tmo_rt;    // Timeout in progress.
	} bmx_stat_t;

	typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
		ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK} bmx_state_t;

endpackage : bmx_pkg

// *** bmx_mux_ctrl.sv ***
// Control and status logic of a two-channel 2-wire bus multiplexer.
// Assumes the upstream clock line is a clock port, the analog buffers and
// switches outside follow chan_switch_o and buffer_en_o, and open-drain pins
// are resolved outside from the output enables.
// How it works
// - Config bit 5 selects connection policy.
// - Config bit 2 enables broadcast write address.
// - Timeout select: off, 30, 15, 7.5 ms.
// - Switch bits 7 and 6 command channels.
// - Logic state bits: data and clock high.
// - Enable low resets bits, ignores bus.
// - Fault inputs reach alert even disabled.
// - Undervoltage releases outputs, ignores bus.
// - Default policy closes only high channels.
// - Multi-channel request connects only high ones.
// - Buffers on only if requested, no timeout.
// - Connection passes traffic and releases ready.
// - Refused connection flags failure, pulls alert.
// - Timeout pulls alert, cuts buffers, keeps switches.
// - Ready low while nothing is connected.
`timescale 1ns/10ps

module bmx_mux_ctrl #(
	parameter int TMO_30_CYC  = bmx_pkg::TMO_30_CYC,  // 30 ms in core cycles.
	parameter int TMO_15_CYC  = bmx_pkg::TMO_15_CYC,  // 15 ms in core cycles.
	parameter int TMO_7P5_CYC = bmx_pkg::TMO_7P5_CYC  // 7.5 ms in core cycles.
) (
	// Core clock and reset.
	input  wire logic       core_clk_i,
	input  wire logic       reset_n_i,
	// Upstream 2-wire link.
	input  wire logic       upstream_clock_line_i,
	input  wire logic       upstream_data_line_i,
	output logic            upstream_data_line_o,
	output logic            upstream_data_line_oe_o,
	// Downstream line levels.
	input  wire logic       chan1_data_line_i,
	input  wire logic       chan1_clock_line_i,
	input  wire logic       chan2_data_line_i,
	input  wire logic       chan2_clock_line_i,
	// Control pins.
	input  wire logic       chan1_fault_in_i,
	input  wire logic       chan2_fault_in_i,
	input  wire logic       enable_i,
	input  wire logic       undervoltage_lockout_i,
	input  wire logic [6:0] dev_addr_i,
	// Switch and buffer controls.
	output logic [1:0]      chan_switch_o,
	output logic            buffer_en_o,
	// Open-drain status pins.
	output logic            alert_o,
	output logic            alert_oe_o,
	output logic            ready_o,
	output logic            ready_oe_o
);

	// ==========================================================
	// Link domain: reset, start detection, synchronisers.
	logic                link_arst_n;   // Any reason to hold the link idle.
	logic                lrst1;         // Reset release stage one.
	logic                link_rst_n;    // Link reset, released on the clock.
	logic                start_tgl;     // Toggles on each start condition.
	logic                start_seen;    // Last start toggle taken.
	logic                start;         // A start precedes this edge.
	logic [14:0]         ls1;           // Link synchroniser stage one.
	logic [14:0]         ls2;           // Link synchroniser stage two.
	bmx_pkg::bmx_stat_t  stat_core;     // Status published by the core.
	bmx_pkg::bmx_stat_t  stat_l;        // Status seen by the link.
	logic [1:0]          lstate;        // Channel logic states.
	logic [6:0]          dev_addr_s;    // Own address strap.

	assign link_arst_n = reset_n_i & enable_i & ~undervoltage_lockout_i;

	// Reset asserts at once and releases on the link clock.
	always_ff @(posedge upstream_clock_line_i or negedge link_arst_n) begin
		if (!link_arst_n) begin
			lrst1      <= 1'b0;
			link_rst_n <= 1'b0;
		end else begin
			lrst1      <= 1'b1;
			link_rst_n <= lrst1;
		end
	end

	// A data fall with the clock high is a start. The clock stays high long
	// enough after it that the link edges can read the toggle directly.
	always_ff @(negedge upstream_data_line_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			start_tgl <= 1'b0;
		end else if (upstream_clock_line_i) begin
			start_tgl <= ~start_tgl;
		end
	end

	// Level crossings into the link domain.
	always_ff @(posedge upstream_clock_line_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			ls1 <= 15'h0000;
			ls2 <= 15'h0000;
		end else begin
			ls1 <= {stat_core, chan1_data_line_i, chan1_clock_line_i,
				chan2_data_line_i, chan2_clock_line_i, dev_addr_i};
			ls2 <= ls1;
		end
	end

	assign stat_l     = ls2[14:11];
	assign lstate     = {ls2[8] & ls2[7], ls2[10] & ls2[9]};
	assign dev_addr_s = ls2[6:0];
	assign start      = start_tgl != start_seen;

	// ==========================================================
	// Link domain: byte engine.
	bmx_pkg::bmx_state_t state;        // Transfer phase.
	logic [2:0]          cnt;          // Bit within the byte.
	logic [7:0]          sh;           // Received bits.
	logic [7:0]          byte_in;      // Byte completed at this edge.
	logic                rw;           // Read requested.
	logic                addr_hit;     // Address byte is ours.
	logic [7:0]          ptr;          // Register pointer.
	logic [7:0]          rd_sh;        // Outgoing read byte.
	logic [7:0]          rd_byte;      // Register selected by the pointer.
	logic                wr_evt;       // Data byte complete.
	logic                drive;        // Pull the data line low next.
	bmx_pkg::bmx_cfg_t   cfg;          // Configuration register.
	logic [1:0]          sw;           // Switch states, bit 0 is channel 1.
	logic                fail;         // A connection was refused.

	assign byte_in  = {sh[6:0], upstream_data_line_i};
	assign addr_hit = (byte_in[7:1] == dev_addr_s) ||
		(cfg.mass_wr_en && byte_in[7:1] == bmx_pkg::MASS_ADDR && !byte_in[0]);
	assign wr_evt   = !start && state == bmx_pkg::ST_WDATA && cnt == 3'h7;

	// Pointer lookup; reserved positions read as zero.
	always_comb begin
		rd_byte = 8'h00;
		if (ptr == bmx_pkg::REG_CFG) begin
			rd_byte[bmx_pkg::CFG_CONN_ANY_BIT] = cfg.conn_any;
			rd_byte[bmx_pkg::CFG_MASS_BIT]     = cfg.mass_wr_en;
			rd_byte[bmx_pkg::CFG_TMO_HI_BIT]   = cfg.tmo_sel[1];
			rd_byte[bmx_pkg::CFG_TMO_LO_BIT]   = cfg.tmo_sel[0];
		end else if (ptr == bmx_pkg::REG_SW) begin
			rd_byte[bmx_pkg::SW_CH1_BIT] = sw[0];
			rd_byte[bmx_pkg::SW_CH2_BIT] = sw[1];
			rd_byte[bmx_pkg::LS_CH1_BIT] = lstate[0];
			rd_byte[bmx_pkg::LS_CH2_BIT] = lstate[1];
		end else if (ptr == bmx_pkg::REG_FAULT) begin
			rd_byte[bmx_pkg::FLT_CONN_BIT]   = stat_l.connected;
			rd_byte[bmx_pkg::FLT_F1_BIT]     = stat_l.fault1;
			rd_byte[bmx_pkg::FLT_F2_BIT]     = stat_l.fault2;
			rd_byte[bmx_pkg::FLT_NOFAIL_BIT] = ~fail;
			rd_byte[bmx_pkg::FLT_TMO_BIT]    = stat_l.tmo_rt;
		end
	end

	// Phase sequence, bits sampled on the rising clock edge.
	always_ff @(posedge upstream_clock_line_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			state      <= bmx_pkg::ST_IDLE;
			cnt        <= 3'h0;
			sh         <= 8'h00;
			rw         <= 1'b0;
			start_seen <= 1'b0;
		end else begin
			start_seen <= start_tgl;
			sh         <= byte_in;
			cnt        <= cnt + 3'h1;
			if (start) begin
				state <= bmx_pkg::ST_ADDR;
				cnt   <= 3'h1;
			end else begin
				unique case (state)
					bmx_pkg::ST_IDLE: begin
						cnt <= 3'h0;
					end
					bmx_pkg::ST_ADDR: begin
						rw <= upstream_data_line_i;
						if (cnt == 3'h7) begin
							state <= addr_hit ? bmx_pkg::ST_ADDR_ACK : bmx_pkg::ST_IDLE;
						end
					end
					bmx_pkg::ST_ADDR_ACK: begin
						cnt   <= 3'h0;
						state <= rw ? bmx_pkg::ST_RDATA : bmx_pkg::ST_CMD;
					end
					bmx_pkg::ST_CMD: begin
						if (cnt == 3'h7) begin
							state <= bmx_pkg::ST_CMD_ACK;
						end
					end
					bmx_pkg::ST_CMD_ACK, bmx_pkg::ST_WDATA_ACK: begin
						cnt   <= 3'h0;
						state <= bmx_pkg::ST_WDATA;
					end
					bmx_pkg::ST_WDATA: begin
						if (cnt == 3'h7) begin
							state <= bmx_pkg::ST_WDATA_ACK;
						end
					end
					bmx_pkg::ST_RDATA: begin
						if (cnt == 3'h7) begin
							state <= bmx_pkg::ST_RDATA_ACK;
						end
					end
					bmx_pkg::ST_RDATA_ACK: begin
						// A high acknowledge ends the read.
						cnt   <= 3'h0;
						state <= upstream_data_line_i ? bmx_pkg::ST_IDLE : bmx_pkg::ST_RDATA;
					end
				endcase
			end
		end
	end

	// Pointer and read shifter.
	always_ff @(posedge upstream_clock_line_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			ptr   <= 8'h00;
			rd_sh <= 8'h00;
		end else begin
			if (!start && state == bmx_pkg::ST_CMD && cnt == 3'h7) begin
				ptr <= byte_in;
			end
			if ((state == bmx_pkg::ST_ADDR_ACK && rw) ||
				(state == bmx_pkg::ST_RDATA_ACK && !upstream_data_line_i)) begin
				rd_sh <= rd_byte;
			end else if (state == bmx_pkg::ST_RDATA) begin
				rd_sh <= {rd_sh[6:0], 1'b0};
			end
		end
	end

	// Configuration writes; reserved bits are dropped.
	always_ff @(posedge upstream_clock_line_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			cfg <= bmx_pkg::CFG_RESET;
		end else if (wr_evt && ptr == bmx_pkg::REG_CFG) begin
			cfg.conn_any   <= byte_in[bmx_pkg::CFG_CONN_ANY_BIT];
			cfg.mass_wr_en <= byte_in[bmx_pkg::CFG_MASS_BIT];
			cfg.tmo_sel    <= {byte_in[bmx_pkg::CFG_TMO_HI_BIT], byte_in[bmx_pkg::CFG_TMO_LO_BIT]};
		end
	end

	// Switch writes. A channel already closed stays closed on a rewrite,
	// since its logic state is meaningless while it is connected.
	always_ff @(posedge upstream_clock_line_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			sw <= 2'h0;
		end else if (wr_evt && ptr == bmx_pkg::REG_SW) begin
			sw[0] <= byte_in[bmx_pkg::SW_CH1_BIT] & (cfg.conn_any | lstate[0] | sw[0]);
			sw[1] <= byte_in[bmx_pkg::SW_CH2_BIT] & (cfg.conn_any | lstate[1] | sw[1]);
		end
	end

	// Refused connection flag; the set wins over a clear.
	always_ff @(posedge upstream_clock_line_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			fail <= 1'b0;
		end else if (wr_evt && ptr == bmx_pkg::REG_SW && !cfg.conn_any &&
			((byte_in[bmx_pkg::SW_CH1_BIT] & ~lstate[0] & ~sw[0]) |
			(byte_in[bmx_pkg::SW_CH2_BIT] & ~lstate[1] & ~sw[1]))) begin
			fail <= 1'b1;
		end else if (wr_evt && ptr == bmx_pkg::REG_FAULT) begin
			fail <= 1'b0;
		end
	end

	// Data line driven on the falling edge so it settles before sampling.
	assign drive = state == bmx_pkg::ST_ADDR_ACK || state == bmx_pkg::ST_CMD_ACK ||
		state == bmx_pkg::ST_WDATA_ACK || (state == bmx_pkg::ST_RDATA && !rd_sh[7]);

	always_ff @(negedge upstream_clock_line_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			upstream_data_line_oe_o <= 1'b0;
		end else begin
			upstream_data_line_oe_o <= drive;
		end
	end

	assign upstream_data_line_o = 1'b0;

	// ==========================================================
	// Core domain: synchronisers and stuck-low timer.
	logic [11:0]         cs1;       // Core synchroniser stage one.
	logic [11:0]         cs2;       // Core synchroniser stage two.
	logic [1:0]          sw_s;      // Switch states.
	logic [1:0]          tmo_sel_s; // Timeout select, taken once stable.
	logic [1:0]          tmo_q;     // Third sample of the timeout select.
	logic                fail_s;    // Refused connection.
	logic                undervoltage_lockout_s;    // Undervoltage lockout.
	logic [1:0]          fault_s;   // Fault input levels.
	logic                stuck;     // A connected line is low.
	logic [bmx_pkg::TMR_W-1:0] tmr; // Stuck-low time.
	logic                tmo_rt;    // Timeout in progress.
	logic                next_buf;  // Buffer path on.

	// Selected limit; zero means the timer is off.
	function automatic logic [bmx_pkg::TMR_W-1:0] tmo_limit(input logic [1:0] sel);
		unique case (sel)
			bmx_pkg::TMO_SEL_30:  tmo_limit = bmx_pkg::TMR_W'(TMO_30_CYC);
			bmx_pkg::TMO_SEL_15:  tmo_limit = bmx_pkg::TMR_W'(TMO_15_CYC);
			bmx_pkg::TMO_SEL_7P5: tmo_limit = bmx_pkg::TMR_W'(TMO_7P5_CYC);
			bmx_pkg::TMO_SEL_OFF: tmo_limit = '0;
		endcase
	endfunction : tmo_limit

	// Level crossings into the core domain.
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			// Fault inputs and lines idle high; a low reset value would fake an alert.
			cs1       <= 12'h03f;
			cs2       <= 12'h03f;
			tmo_q     <= bmx_pkg::TMO_SEL_OFF;
			tmo_sel_s <= bmx_pkg::TMO_SEL_OFF;
		end else begin
			cs1 <= {sw, cfg.tmo_sel, fail, undervoltage_lockout_i, chan1_fault_in_i, chan2_fault_in_i,
				chan1_data_line_i, chan1_clock_line_i, chan2_data_line_i, chan2_clock_line_i};
			cs2 <= cs1;
			tmo_q <= cs2[9:8];
			// The select is a two-bit code; one caught mid-change must not pick a shorter limit.
			if (cs2[9:8] == tmo_q) begin
				tmo_sel_s <= tmo_q;
			end
		end
	end

	assign sw_s      = cs2[11:10];
	assign fail_s    = cs2[7];
	assign undervoltage_lockout_s    = cs2[6];
	assign fault_s   = cs2[5:4];
	assign stuck     = (sw_s[0] & ~(cs2[3] & cs2[2])) | (sw_s[1] & ~(cs2[1] & cs2[0]));

	// Timer runs while stuck, restarts when the lines recover.
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tmr    <= '0;
			tmo_rt <= 1'b0;
		end else if (!stuck || tmo_sel_s == bmx_pkg::TMO_SEL_OFF) begin
			tmr    <= '0;
			tmo_rt <= 1'b0;
		end else if (tmr >= tmo_limit(tmo_sel_s) - bmx_pkg::TMR_W'(1)) begin
			tmo_rt <= 1'b1;
		end else begin
			tmr <= tmr + bmx_pkg::TMR_W'(1);
		end
	end

	// Buffers follow the switches only while no timeout stands.
	assign next_buf = ~undervoltage_lockout_s & (|sw_s) & ~tmo_rt;

	// Registered pin controls; ready is pulled down while unconnected.
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			buffer_en_o   <= 1'b0;
			chan_switch_o <= 2'h0;
			alert_oe_o    <= 1'b0;
			ready_oe_o    <= 1'b0;
		end else begin
			buffer_en_o   <= next_buf;
			chan_switch_o <= undervoltage_lockout_s ? 2'h0 : sw_s;
			alert_oe_o    <= ~undervoltage_lockout_s & (~fault_s[0] | ~fault_s[1] | fail_s | tmo_rt);
			ready_oe_o    <= ~undervoltage_lockout_s & ~next_buf;
		end
	end

	assign stat_core = '{connected: buffer_en_o, fault1: fault_s[1], fault2: fault_s[0], tmo_rt: tmo_rt};
	assign alert_o   = 1'b0;
	assign ready_o   = 1'b0;

	// ==========================================================
	// Checks.
	ready_pair_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		$past(reset_n_i) |-> ready_oe_o == (!buffer_en_o && !$past(undervoltage_lockout_s)))
		else $error("ready does not mirror the buffer state");
	buf_gate_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		buffer_en_o |-> $past(sw_s != 2'h0 && !tmo_rt))
		else $error("buffers on without request or during timeout");
	tmo_cut_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		tmo_rt && !undervoltage_lockout_s |=> !buffer_en_o && alert_oe_o)
		else $error("timeout left buffers on or alert off");
	tmo_off_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		tmo_sel_s == bmx_pkg::TMO_SEL_OFF |=> !tmo_rt)
		else $error("timeout while disabled");
	fault_alert_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		!undervoltage_lockout_s && fault_s != 2'h3 |=> alert_oe_o)
		else $error("fault input not forwarded");
	undervoltage_lockout_quiet_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		undervoltage_lockout_s |=> !alert_oe_o && !buffer_en_o && !ready_oe_o)
		else $error("outputs driven in lockout");
	fail_alert_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		fail_s && !undervoltage_lockout_s |=> alert_oe_o)
		else $error("refused connection without alert");
	refuse_low_a: assert property (@(posedge upstream_clock_line_i) disable iff (!link_rst_n)
		wr_evt && ptr == bmx_pkg::REG_SW && !cfg.conn_any && !lstate[0] && !sw[0] |=> !sw[0])
		else $error("low channel 1 connected");
	refuse_flag_a: assert property (@(posedge upstream_clock_line_i) disable iff (!link_rst_n)
		wr_evt && ptr == bmx_pkg::REG_SW && !cfg.conn_any && byte_in[bmx_pkg::SW_CH2_BIT] && !lstate[1]
		&& !sw[1] |=> fail && !sw[1])
		else $error("low channel 2 not refused");
	resv_zero_a: assert property (@(posedge upstream_clock_line_i) disable iff (!link_rst_n)
		ptr == bmx_pkg::REG_CFG |-> rd_byte[7:6] == 2'h0 && rd_byte[4:3] == 2'h0)
		else $error("reserved bits read nonzero");

endmodule : bmx_mux_ctrl

// *** bmx_master_model.sv ***
// Upstream 2-wire master model: drives the link clock and data line.
// Assumes a pull-up on the data line; the device only drives its enable.
`timescale 1ns/10ps

module bmx_master_model (
	// Device side.
	input  wire logic  dev_oe_i,
	output logic       scl_o,
	output logic       sda_o,
	// Read results.
	output logic [7:0] rd_data_o,
	output logic       rd_valid_o
);
	logic sda_drv = 1'b1; // Own level, 1 = released.

	// ==========================================================
	// Wired-and line; the clock idles high between frames.
	assign sda_o = sda_drv & ~dev_oe_i;
	initial begin
		scl_o = 1'b1;
		rd_data_o = 8'h00;
		rd_valid_o = 1'b0;
	end

	// One bit; data changes only while the clock is low.
	task automatic xfer_bit(input logic b, output logic r);
		sda_drv = b;
		#12 scl_o = 1'b1;
		#24 r = sda_o;
		scl_o = 1'b0;
		#12;
	endtask : xfer_bit

	// Two bare pulses let the link reset release.
	task automatic pulses;
		logic r;
		xfer_bit(1'b1, r);
		xfer_bit(1'b1, r);
		scl_o = 1'b1;
	endtask : pulses

	task automatic start_cond;
		sda_drv = 1'b1;
		#12 scl_o = 1'b1;
		#12 sda_drv = 1'b0;
		#12 scl_o = 1'b0;
		#12;
	endtask : start_cond

	task automatic stop_cond;
		sda_drv = 1'b0;
		#12 scl_o = 1'b1;
		#12 sda_drv = 1'b1;
		#12;
	endtask : stop_cond

	// Eight bits MSB first, then the ninth bit read back as the acknowledge.
	task automatic send_byte(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(v[i], r);
		end
		xfer_bit(1'b1, r);
		ack = ~r;
	endtask : send_byte

	// Address, pointer and one data byte; returns the address acknowledge.
	task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ack);
		logic k;
		start_cond();
		send_byte({a, 1'b0}, ack);
		send_byte(p, k);
		send_byte(d, k);
		stop_cond();
	endtask : write_reg

	// Pointer write, repeated start, one byte read and closed with a NACK.
	task automatic read_reg(input logic [6:0] a, input logic [7:0] p);
		logic       k;
		logic [7:0] d;
		start_cond();
		send_byte({a, 1'b0}, k);
		send_byte(p, k);
		start_cond();
		send_byte({a, 1'b1}, k);
		for (int i = 0; i < 8; i++) begin
			xfer_bit(1'b1, k);
			d = {d[6:0], k};
		end
		xfer_bit(1'b1, k);
		stop_cond();
		rd_data_o = d;
		rd_valid_o = 1'b1;
		#5 rd_valid_o = 1'b0;
	endtask : read_reg
endmodule : bmx_master_model

// *** bmx_mux_ctrl_tb.sv ***
// Self-checking bench of the bus mux control block.
// Assumes the master model stands on the upstream link.
`timescale 1ns/10ps

module bmx_mux_ctrl_tb;
	localparam logic [6:0] ADDR = 7'h4a; // Own address strap, arbitrary.
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  ins = 8'hbf; // {en, undervoltage_lockout, f1, f2, c1d, c1c, c2d, c2c}.
	logic        scl, sda, oe, d_o, buf_en, al, al_oe, rdy, rdy_oe, rv;
	logic [1:0]  sw;
	logic [7:0]  rd;
	logic [7:0]  exp_q[$];
	logic [31:0] seed = 32'hc1b51d5c;
	int          bad_count = 0;
	int          comparisons = 0;
	int          cycles = 0;

	always #5 clk = ~clk;

	bmx_mux_ctrl #(.TMO_30_CYC(40), .TMO_15_CYC(20), .TMO_7P5_CYC(10)) i_bmx_mux_ctrl (
		.core_clk_i(clk), .reset_n_i(rst_n), .upstream_clock_line_i(scl),
		.upstream_data_line_i(sda), .upstream_data_line_o(d_o), .upstream_data_line_oe_o(oe),
		.chan1_data_line_i(ins[3]), .chan1_clock_line_i(ins[2]), .chan2_data_line_i(ins[1]),
		.chan2_clock_line_i(ins[0]), .chan1_fault_in_i(ins[5]), .chan2_fault_in_i(ins[4]),
		.enable_i(ins[7]), .undervoltage_lockout_i(ins[6]), .dev_addr_i(ADDR),
		.chan_switch_o(sw), .buffer_en_o(buf_en), .alert_o(al), .alert_oe_o(al_oe),
		.ready_o(rdy), .ready_oe_o(rdy_oe));

	bmx_master_model i_bmx_master_model (.dev_oe_i(oe), .scl_o(scl), .sda_o(sda),
		.rd_data_o(rd), .rd_valid_o(rv));

	// ==========================================================
	// Checking and closing.
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	task automatic conclude;
		$display("Comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude

	// Each read byte is paired with the oldest expectation.
	always @(posedge rv) begin
		if (exp_q.size() == 0) begin
			bad_count++;
			$display("[ERR] %0t got %h with no expectation", $time, rd);
		end else begin
			check(rd, exp_q.pop_front());
		end
	end

	// A hung link would stall the run, so cycles are capped.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			conclude();
		end
	end

	// ==========================================================
	// Stimulus helpers; pins land at falling core edges.
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	task automatic drive(input logic [7:0] v);
		@(negedge clk);
		ins = v;
	endtask : drive

	// Outputs follow after three sync cycles, so six is ample. The open-drain
	// values never change, so they ride along as zeros.
	task automatic pins(input logic [4:0] e);
		repeat (6) @(negedge clk);
		check({d_o, al, rdy, al_oe, rdy_oe, buf_en, sw}, {3'h0, e});
	endtask : pins

	task automatic rd_chk(input logic [7:0] p, input logic [7:0] e);
		exp_q.push_back(e);
		i_bmx_master_model.read_reg(ADDR, p);
	endtask : rd_chk

	task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, input logic e);
		logic k;
		i_bmx_master_model.write_reg(a, p, d, k);
		check({7'h0, k}, {7'h0, e});
	endtask : wr

	// ==========================================================
	// Main sequence.
	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		i_bmx_master_model.pulses();
		pins(5'b01000);
		drive(8'hbd);
		rd_chk(bmx_pkg::REG_CFG, 8'h04);
		rd_chk(bmx_pkg::REG_SW, 8'h08);
		wr(ADDR, bmx_pkg::REG_SW, 8'hc0, 1'b1);
		pins(5'b10101);
		rd_chk(bmx_pkg::REG_FAULT, 8'he0);
		wr(ADDR, bmx_pkg::REG_FAULT, 8'h00, 1'b1);
		pins(5'b00101);
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			wr(ADDR, bmx_pkg::REG_CFG, {seed[7:2], i[1:0]}, 1'b1);
			rd_chk(bmx_pkg::REG_CFG, {seed[7:2], i[1:0]} & 8'h27);
		end
		wr(ADDR, bmx_pkg::REG_CFG, 8'h20, 1'b1);
		wr(bmx_pkg::MASS_ADDR, bmx_pkg::REG_CFG, 8'h24, 1'b0);
		rd_chk(bmx_pkg::REG_CFG, 8'h20);
		wr(ADDR, bmx_pkg::REG_SW, 8'h40, 1'b1);
		pins(5'b00110);
		wr(ADDR, bmx_pkg::REG_CFG, 8'h23, 1'b1);
		repeat (30) @(negedge clk);
		pins(5'b11010);
		drive(8'h1f);
		pins(5'b11000);
		wr(ADDR, bmx_pkg::REG_SW, 8'h80, 1'b0);
		drive(8'hbf);
		i_bmx_master_model.pulses();
		rd_chk(bmx_pkg::REG_CFG, 8'h04);
		wr(bmx_pkg::MASS_ADDR, bmx_pkg::REG_CFG, 8'h05, 1'b1);
		rd_chk(bmx_pkg::REG_CFG, 8'h05);
		drive(8'hb7);
		wr(ADDR, bmx_pkg::REG_SW, 8'h80, 1'b1);
		pins(5'b11000);
		drive(8'hdf);
		pins(5'b00000);
		wr(ADDR, bmx_pkg::REG_SW, 8'h80, 1'b0);
		if (exp_q.size() != 0) begin
			bad_count++;
			$display("[ERR] %0t got %h reads exp %h reads", $time, 8'h00, exp_q.size());
		end
		conclude();
	end
endmodule : bmx_mux_ctrl_tb
